/* File: eeprom_twowire_defs.svh */
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_TWOWIRE_DEFS_SVH
`define EEPROM_TWOWIRE_DEFS_SVH

// array and page geometry
`define ADDR_W          15
`define PAGE_W          6
`define PAGE_BYTES      64
`define MEM_WORDS       32768
`define TOP_WORD_ADDRESS_BIT 14
`define ADDR_HI_LSB     8

// control byte fields
`define CTRL_CODE_HI    7
`define CTRL_CODE_LO    4
`define CTRL_CS_HI      3
`define CTRL_CS_LO      1
`define CTRL_RW_BIT     0

// device type code: arbitrary value, not a real part code
`define DEVICE_TYPE_DEFAULT 4'h5

// bit counter within a byte frame
`define BIT_CNT_W       4
`define BIT_LAST        4'h7
`define BIT_ACK         4'h8

// synchronised pin vector layout
`define PIN_W           6
`define PIN_SCL         0
`define PIN_SDA         1
`define PIN_WP          2
`define PIN_CS_LO       3
`define PIN_CS_HI       5

// write cycle timing
`define WRITE_TIME_MS   5
`define CLK_KHZ         100000
`define WC_W            20
`define COPY_W          7

`endif

/* File: eeprom_twowire_pkg.sv */
// types shared by the two-wire serial eeprom slave
package eeprom_twowire_pkg;

   // protocol phase of the byte-level state machine
   typedef enum logic [2:0] {
      ph_idle,
      ph_ctrl,
      ph_addr_hi,
      ph_addr_lo,
      ph_wdata,
      ph_rdata,
      ph_ignore
   } phase_e;

   // chip select strap pins
   typedef struct packed {
      logic chip_select_pin_2;
      logic chip_select_pin_1;
      logic chip_select_pin_0;
   } chip_select_s;

   // open-drain data pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } sda_drive_s;

endpackage : eeprom_twowire_pkg

/* File: link_shifter.sv */
// serial clock domain bit sampler for the two-wire link
`timescale 1ns/10ps

module link_shifter (
   input  wire logic       scl_clk,
   input  wire logic       sda_in,
   output logic [7:0]      link_byte
);

   // data is stable while the serial clock is high, so the rising edge takes it
   always_ff @(posedge scl_clk) begin
      link_byte <= {link_byte[6:0], sda_in};
   end

endmodule : link_shifter

/* File: serial_eeprom_twowire_slave.sv */
// two-wire serial eeprom slave: protocol engine, page buffer and array
`timescale 1ns/10ps

`include "eeprom_twowire_defs.svh"

module serial_eeprom_twowire_slave
   import eeprom_twowire_pkg::*;
#(
   parameter logic [3:0]  DEVICE_TYPE_CODE = `DEVICE_TYPE_DEFAULT,
   parameter int unsigned WRITE_CYCLES     = `WRITE_TIME_MS * `CLK_KHZ
) (
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   input  wire logic                        scl_clk,
   input  wire logic                        sda_in,
   input  wire eeprom_twowire_pkg::chip_select_s chip_select,
   input  wire logic                        write_protect,
   output eeprom_twowire_pkg::sda_drive_s   sda,
   output logic                             write_busy
);
   import eeprom_twowire_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [`PIN_W-1:0]     pin_raw;
   logic [`PIN_W-1:0]     pin_meta;
   logic [`PIN_W-1:0]     pin_sync;
   logic                  scl_prev;
   logic                  sda_prev;
   logic                  scl_s;
   logic                  sda_s;
   logic                  wp_s;
   logic [2:0]            cs_s;

   logic                  start_seen;
   logic                  stop_seen;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  rx_done;
   logic                  ack_clk;
   logic                  ctrl_match;
   logic                  buf_we;

   logic [7:0]            link_byte;
   phase_e                phase;
   phase_e                pend_phase;
   logic [`BIT_CNT_W-1:0] bit_cnt;
   logic [`ADDR_W-1:0]    ptr;
   logic                  ack_go;
   logic                  wr_pending;
   logic [7:0]            tx_byte;
   logic [2:0]            tx_idx;

   logic [7:0]            mem [`MEM_WORDS];
   logic [7:0]            page_buf [`PAGE_BYTES];
   logic [`PAGE_BYTES-1:0] buf_valid;
   logic                  buf_clear;
   logic [`ADDR_W-`PAGE_W-1:0] commit_page;
   logic [`WC_W-1:0]      wc_count;
   logic [`COPY_W-1:0]    copy_idx;
   logic                  copy_on;
   logic                  commit_start;

   ////////////////////////////////////////////////////////////////////////////
   // link clock domain: byte sampler

   // bits are shifted on the serial clock itself; the byte is read here only
   // after a synchronised rising edge, long before the next edge can move it
   link_shifter u_link_shifter (
      .scl_clk   (scl_clk),
      .sda_in    (sda_in),
      .link_byte (link_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   assign pin_raw = {chip_select, write_protect, sda_in, scl_clk};

   // two flip-flops per pin before any clk_sys logic looks at it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_meta <= {`PIN_W{1'b1}};
         pin_sync <= {`PIN_W{1'b1}};
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // previous sample for edge detection, taken from the second stage only
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= pin_sync[`PIN_SCL];
         sda_prev <= pin_sync[`PIN_SDA];
      end
   end

   assign scl_s = pin_sync[`PIN_SCL];
   assign sda_s = pin_sync[`PIN_SDA];
   assign wp_s  = pin_sync[`PIN_WP];
   assign cs_s  = pin_sync[`PIN_CS_HI:`PIN_CS_LO];

   ////////////////////////////////////////////////////////////////////////////
   // bus conditions and frame events

   // data edges while the clock stays high are conditions, not data
   assign start_seen = scl_s && scl_prev && sda_prev && !sda_s;
   assign stop_seen  = scl_s && scl_prev && !sda_prev && sda_s;
   assign scl_rise   = scl_s && !scl_prev;
   assign scl_fall   = !scl_s && scl_prev;
   assign rx_done    = scl_rise && (bit_cnt == `BIT_LAST);
   assign ack_clk    = scl_rise && (bit_cnt == `BIT_ACK);

   // type code, chip selects and an idle array are all needed to answer
   assign ctrl_match = (link_byte[`CTRL_CODE_HI:`CTRL_CODE_LO] == DEVICE_TYPE_CODE)
                    && (link_byte[`CTRL_CS_HI:`CTRL_CS_LO] == cs_s)
                    && !write_busy;

   assign buf_we    = rx_done && (phase == ph_wdata);
   assign buf_clear = rx_done && (phase == ph_ctrl) && ctrl_match
                   && !link_byte[`CTRL_RW_BIT];
   assign tx_idx    = 3'(`BIT_LAST - bit_cnt);

   ////////////////////////////////////////////////////////////////////////////
   // byte-level protocol state machine

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase      <= ph_idle;
         pend_phase <= ph_idle;
         bit_cnt    <= '0;
         ptr        <= '0;
         ack_go     <= 1'b0;
         wr_pending <= 1'b0;
         tx_byte    <= 8'h00;
      end else if (start_seen) begin
         // a start anywhere restarts framing; an unfinished write is dropped
         phase      <= ph_ctrl;
         bit_cnt    <= '0;
         ack_go     <= 1'b0;
         wr_pending <= 1'b0;
      end else if (stop_seen) begin
         phase      <= ph_idle;
         bit_cnt    <= '0;
         ack_go     <= 1'b0;
         wr_pending <= 1'b0;
      end else begin
         if (scl_fall) begin
            ack_go <= 1'b0;
         end
         if (scl_rise) begin
            // one bit per clock pulse, ninth pulse carries the acknowledge
            if (bit_cnt == `BIT_ACK) begin
               bit_cnt <= '0;
            end else begin
               bit_cnt <= bit_cnt + 1'b1;
            end
         end
         if (rx_done) begin
            case (phase)
               ph_ctrl: begin
                  if (ctrl_match) begin
                     ack_go <= 1'b1;
                     if (link_byte[`CTRL_RW_BIT]) begin
                        pend_phase <= ph_rdata;
                     end else begin
                        pend_phase <= ph_addr_hi;
                     end
                  end else begin
                     pend_phase <= ph_ignore;
                  end
               end
               ph_addr_hi: begin
                  // highest received bit is a don't care
                  ptr[`TOP_WORD_ADDRESS_BIT:`ADDR_HI_LSB] <= link_byte[6:0];
                  ack_go     <= 1'b1;
                  pend_phase <= ph_addr_lo;
               end
               ph_addr_lo: begin
                  ptr[`ADDR_HI_LSB-1:0] <= link_byte;
                  ack_go     <= 1'b1;
                  pend_phase <= ph_wdata;
               end
               ph_wdata: begin
                  // low six bits roll over, so the page never changes
                  ptr[`PAGE_W-1:0] <= ptr[`PAGE_W-1:0] + 1'b1;
                  wr_pending <= 1'b1;
                  ack_go     <= 1'b1;
                  pend_phase <= ph_wdata;
               end
               ph_rdata: begin
                  // full-width wrap keeps the pointer inside this array
                  ptr        <= ptr + 1'b1;
                  pend_phase <= ph_rdata;
               end
               default: begin
                  pend_phase <= phase;
               end
            endcase
         end
         if (ack_clk) begin
            if (phase == ph_rdata) begin
               // master acknowledge asks for the next byte; none ends the read
               if (sda_s) begin
                  phase <= ph_ignore;
               end else begin
                  tx_byte <= mem[ptr];
               end
            end else begin
               phase <= pend_phase;
               if (pend_phase == ph_rdata) begin
                  tx_byte <= mem[ptr];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data pin driver

   // changes happen after a synchronised falling clock edge, or at a start or stop, which releases the pin
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sda.oe  <= 1'b0;
         sda.out <= 1'b0;
      end else begin
         sda.out <= 1'b0;
         if (start_seen || stop_seen) begin
            sda.oe <= 1'b0;
         end else if (scl_fall) begin
            if (ack_go) begin
               sda.oe <= 1'b1;
            end else if (phase == ph_rdata && bit_cnt <= `BIT_LAST) begin
               sda.oe <= !tx_byte[tx_idx];
            end else begin
               sda.oe <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffer

   // data lands in the buffer, not the array, until the stop
   always_ff @(posedge clk_sys) begin
      if (buf_we) begin
         page_buf[ptr[`PAGE_W-1:0]] <= link_byte;
      end
   end

   // valid flags mark which buffer bytes the commit writes back
   always_ff @(posedge clk_sys) begin
      if (srst || buf_clear) begin
         buf_valid <= '0;
      end else if (buf_we) begin
         buf_valid[ptr[`PAGE_W-1:0]] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write cycle

   // protect level is looked at only at the stop that ends a write
   assign commit_start = stop_seen && wr_pending && !wp_s && !write_busy;

   // busy flag and timer; the pin may move freely once the cycle runs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         write_busy  <= 1'b0;
         wc_count    <= '0;
         commit_page <= '0;
      end else if (commit_start) begin
         write_busy  <= 1'b1;
         wc_count    <= `WC_W'(WRITE_CYCLES - 1);
         commit_page <= ptr[`ADDR_W-1:`PAGE_W];
      end else if (write_busy) begin
         if (wc_count == '0) begin
            write_busy <= 1'b0;
         end else begin
            wc_count <= wc_count - 1'b1;
         end
      end
   end

   // copy walks the buffer one entry per cycle at the start of the cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         copy_idx <= '0;
         copy_on  <= 1'b0;
      end else if (commit_start) begin
         copy_idx <= '0;
         copy_on  <= 1'b1;
      end else if (copy_on) begin
         if (copy_idx == `COPY_W'(`PAGE_BYTES - 1)) begin
            copy_on <= 1'b0;
         end
         copy_idx <= copy_idx + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array

   // only buffered bytes are written, all inside the latched page
   always_ff @(posedge clk_sys) begin
      if (copy_on && buf_valid[copy_idx[`PAGE_W-1:0]]) begin
         mem[{commit_page, copy_idx[`PAGE_W-1:0]}] <= page_buf[copy_idx[`PAGE_W-1:0]];
      end
   end

endmodule : serial_eeprom_twowire_slave

/* File: eeprom_twowire_monitor.sv */
// assertion checker for the two-wire eeprom slave ports
`timescale 1ns/10ps
module eeprom_twowire_monitor #(
   parameter int unsigned WRITE_CYCLES = 600
) (
   input wire logic                              clk_sys,
   input wire logic                              srst,
   input wire logic                              scl_clk,
   input wire logic                              sda_in,
   input wire eeprom_twowire_pkg::chip_select_s  chip_select,
   input wire logic                              write_protect,
   input wire eeprom_twowire_pkg::sda_drive_s    sda,
   input wire logic                              write_busy
);
   import eeprom_twowire_pkg::*;
   int unsigned busy_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   ////////////////////////////////////////
   // length of the current write cycle
   always_ff @(posedge clk_sys) begin
      if (srst || !write_busy) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   ////////////////////////////////////////
   property p_no_ack_busy; write_busy |-> !sda.oe; endproperty
   a_no_ack_busy:
      assert property (p_no_ack_busy) else $error("data driven during write cycle");
   property p_oe_scl_low; $changed(sda.oe) |-> !scl_clk && !$past(scl_clk, 2); endproperty
   a_oe_scl_low:
      assert property (p_oe_scl_low) else $error("drive changed with clock high");
   property p_oe_hold; scl_clk && $past(scl_clk) |-> $stable(sda.oe); endproperty
   a_oe_hold:
      assert property (p_oe_hold) else $error("drive not held over clock high");
   property p_busy_len;
      $fell(write_busy) |-> busy_cnt + 1 >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 1;
   endproperty
   a_busy_len:
      assert property (p_busy_len) else $error("write cycle length wrong");
   property p_busy_idle; $rose(write_busy) |-> scl_clk && sda_in; endproperty
   a_busy_idle:
      assert property (p_busy_idle) else $error("write cycle began off a stop");
   // the design looks at the pin two flip-flops late, at the edge two before busy rises
   property p_busy_wp; $rose(write_busy) |-> !$past(write_protect, 3); endproperty
   a_busy_wp:
      assert property (p_busy_wp) else $error("write cycle while protected");
   property p_stop_quiet; scl_clk && $rose(sda_in) |=> !sda.oe [*8]; endproperty
   a_stop_quiet:
      assert property (p_stop_quiet) else $error("drive after stop");
   property p_start_quiet; scl_clk && $fell(sda_in) |=> !sda.oe [*8]; endproperty
   a_start_quiet:
      assert property (p_start_quiet) else $error("drive after start");
endmodule : eeprom_twowire_monitor

/* File: twowire_master.sv */
// two-wire bus master model driving clock and data
`timescale 1ns/10ps
module twowire_master #(
   parameter int HALF = 30
) (
   input  wire logic sda_line,
   output logic      scl_clk,
   output logic      sda_pull
);
   logic lclk = 1'b0;
   ////////////////////////////////////////
   // link tick, 6 ns period; serial clock idles high
   always #3 lclk = ~lclk;
   initial begin
      scl_clk = 1'b1;
      sda_pull = 1'b0;
   end
   ////////////////////////////////////////
   task half;
      repeat (HALF) @(posedge lclk);
   endtask : half
   // clock falls, data waits well clear of the edge
   task fall;
      scl_clk <= 1'b0;
      repeat (8) @(posedge lclk);
   endtask : fall
   task pulse;
      half;
      scl_clk <= 1'b1;
      half;
      fall;
   endtask : pulse
   // start from idle or repeated start
   task start;
      if (!scl_clk) begin
         sda_pull <= 1'b0;
         half;
         scl_clk <= 1'b1;
         half;
      end
      sda_pull <= 1'b1;
      half;
      fall;
   endtask : start
   task stop;
      sda_pull <= 1'b1;
      half;
      scl_clk <= 1'b1;
      half;
      sda_pull <= 1'b0;
      half;
   endtask : stop
   // n bits msb first, ack clock only for a whole byte
   task wbyte(input logic [7:0] d, input int n, output logic ack);
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         sda_pull <= ~d[i];
         pulse;
      end
      if (n == 8) begin
         sda_pull <= 1'b0;
         half;
         scl_clk <= 1'b1;
         half;
         ack = !sda_line;
         fall;
      end
   endtask : wbyte
   task rbyte(input logic mack, output logic [7:0] d);
      sda_pull <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         half;
         scl_clk <= 1'b1;
         half;
         d[i] = sda_line;
         fall;
      end
      sda_pull <= mack;
      pulse;
   endtask : rbyte
endmodule : twowire_master

/* File: testbench.sv */
// self-checking testbench for the two-wire eeprom slave
`timescale 1ns/10ps
module testbench;
   import eeprom_twowire_pkg::*;
   localparam int unsigned WC = 600;
   logic         clk_sys = 1'b0;
   logic         srst = 1'b1;
   logic         write_protect = 1'b0;
   chip_select_s chip_select = 3'b101;
   sda_drive_s   sda;
   logic         write_busy, scl_clk, sda_pull, sda_line, ack;
   logic [7:0]   xb [0:3];
   logic [7:0]   rd_b;
   int           miscompares = 0;
   int           tests_run = 0;
   ////////////////////////////////////////
   always #5 clk_sys = ~clk_sys;
   // pulled-up data wire
   assign sda_line = !(sda_pull || (sda.oe && !sda.out));
   serial_eeprom_twowire_slave #(.WRITE_CYCLES(WC)) serial_eeprom_twowire_slave_inst (
      .clk_sys(clk_sys), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_line),
      .chip_select(chip_select), .write_protect(write_protect), .sda(sda), .write_busy(write_busy));
   twowire_master twowire_master_inst (.sda_line(sda_line), .scl_clk(scl_clk), .sda_pull(sda_pull));
   ////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task chk_ack(input logic exp);
      check({7'h0, ack}, {7'h0, exp});
   endtask : chk_ack
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   function logic [7:0] ctrl_byte(input logic rw);
      return {4'h5, 3'b101, rw};
   endfunction : ctrl_byte
   // start, write control and word address
   task addr_cmd(input logic [15:0] a);
      twowire_master_inst.start;
      twowire_master_inst.wbyte(ctrl_byte(1'b0), 8, ack);
      chk_ack(1'b1);
      twowire_master_inst.wbyte(a[15:8], 8, ack);
      chk_ack(1'b1);
      twowire_master_inst.wbyte(a[7:0], 8, ack);
      chk_ack(1'b1);
   endtask : addr_cmd
   task wr(input logic [15:0] a, input int n);
      addr_cmd(a);
      for (int i = 0; i < n; i++) begin
         twowire_master_inst.wbyte(xb[i], 8, ack);
         chk_ack(1'b1);
      end
      twowire_master_inst.stop;
   endtask : wr
   // random or current read of n bytes, last one not acknowledged
   task rd(input logic [15:0] a, input int n, input logic cur);
      if (!cur) addr_cmd(a);
      twowire_master_inst.start;
      twowire_master_inst.wbyte(ctrl_byte(1'b1), 8, ack);
      chk_ack(1'b1);
      for (int i = 0; i < n; i++) begin
         twowire_master_inst.rbyte(i < n - 1, rd_b);
         check(rd_b, xb[i]);
      end
      check({7'h0, sda.oe}, 8'h00);
      twowire_master_inst.stop;
   endtask : rd
   task wait_busy(input logic exp);
      logic seen;
      seen = 1'b0;
      // look between edges so the flag is settled when sampled
      repeat (20) begin
         @(negedge clk_sys);
         seen = seen | write_busy;
      end
      @(posedge clk_sys);
      check({7'h0, seen}, {7'h0, exp});
   endtask : wait_busy
   // acknowledge polling, first try must be refused
   task poll;
      int k;
      k = 0;
      do begin
         twowire_master_inst.start;
         twowire_master_inst.wbyte(ctrl_byte(1'b0), 8, ack);
         twowire_master_inst.stop;
         k++;
      end while (ack !== 1'b1 && k < 50);
      chk_ack(1'b1);
      check({7'h0, k > 1}, 8'h01);
      if (ack !== 1'b1) tally_and_finish;
   endtask : poll
   ////////////////////////////////////////
   // watchdog
   initial begin
      repeat (95000) @(posedge clk_sys);
      miscompares++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check({5'h0, sda.out, sda.oe, write_busy}, 8'h00);
      twowire_master_inst.start;
      twowire_master_inst.wbyte(8'h3a, 8, ack);
      chk_ack(1'b0);
      twowire_master_inst.stop;
      @(posedge clk_sys);
      chip_select <= 3'b011;
      repeat (4) @(posedge clk_sys);
      twowire_master_inst.start;
      twowire_master_inst.wbyte(ctrl_byte(1'b0), 8, ack);
      chk_ack(1'b0);
      twowire_master_inst.stop;
      @(posedge clk_sys);
      chip_select <= 3'b101;
      xb[0] = 8'h5a;
      wr(16'h0c02, 1);
      wait_busy(1'b1);
      write_protect <= 1'b1;
      poll;
      @(posedge clk_sys);
      write_protect <= 1'b0;
      xb = '{8'h11, 8'h22, 8'h33, 8'h44};
      wr(16'h8c3e, 4);
      wait_busy(1'b1);
      poll;
      xb[0] = 8'h5a;
      rd(16'h0, 1, 1'b1);
      xb = '{8'h33, 8'h44, 8'h5a, 8'h00};
      rd(16'h0c00, 3, 1'b0);
      xb = '{8'h11, 8'h22, 8'h00, 8'h00};
      rd(16'h0c3e, 2, 1'b0);
      @(posedge clk_sys);
      write_protect <= 1'b1;
      xb[0] = 8'hee;
      wr(16'h0c02, 1);
      wait_busy(1'b0);
      write_protect <= 1'b0;
      xb[0] = 8'h5a;
      rd(16'h0c02, 1, 1'b0);
      xb[0] = 8'hc3;
      wr(16'hffff, 1);
      poll;
      xb[0] = 8'h3c;
      wr(16'h8000, 1);
      poll;
      xb = '{8'hc3, 8'h3c, 8'h00, 8'h00};
      rd(16'h7fff, 2, 1'b0);
      addr_cmd(16'h0c02);
      twowire_master_inst.wbyte(8'h99, 4, ack);
      twowire_master_inst.stop;
      xb[0] = 8'h5a;
      rd(16'h0c02, 1, 1'b0);
      tally_and_finish;
   end
endmodule : testbench

bind serial_eeprom_twowire_slave eeprom_twowire_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_twowire_monitor_inst (
   .clk_sys(clk_sys), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_in), .chip_select(chip_select),
   .write_protect(write_protect), .sda(sda), .write_busy(write_busy));
